//--- core/cucc_config_chains.sv
// Purpose: Boot, runtime and error-capture chains of the cache unit
// Assumes: Privileged access strobes and retire come from the core clock domain
// Notes: Boot load starts once self-test is done after reset

`timescale 1ns/10ps
`default_nettype none

module cucc_config_chains
    import cucc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Self-test status
    input wire logic builtin_self_test_done_i,
    // Serial configuration ROM
    input wire logic rom_data_i,
    output logic rom_clk_o,
    output logic rom_enable_o,
    // Privileged register access
    input wire logic preg_priv_i,
    input wire logic preg_wr_i,
    input wire logic preg_rd_i,
    input wire logic preg_sel_i,
    input wire logic [REG_W-1:0] preg_wdata_i,
    input wire logic preg_retire_i,
    output logic [REG_W-1:0] preg_rdata_o,
    output logic preg_rvalid_o,
    // Error capture
    input wire logic err_capture_i,
    input wire logic [ERR_BITS-1:0] err_data_i,
    // Configuration outputs
    output logic cache_ready_o,
    output logic io32_enable_o,
    output logic skewed_fill_bit_o,
    output logic skewed_fill_dup_o,
    output logic [VICTIM_W-1:0] victim_threshold_o,
    output logic clean_evict_enable_o,
    output logic [BUS_WIDTH_W-1:0] system_bus_width_o,
    output logic system_bus_layout_o,
    output logic [CLK_MULT_W-1:0] system_clock_multiplier_o,
    output logic [1:0] ratio_sel_o,
    output logic ratio_valid_o,
    output logic shadow_tag_enable_o,
    output logic snoop_tag_only_o,
    output logic fast_mode_enable_o,
    output logic [RT_BITS-1:0] runtime_chain_o
);

    // =========================================================
    // ROM data synchroniser
    // =========================================================
    logic rom_meta;
    logic rom_sync;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rom_meta <= 1'b0;
            rom_sync <= 1'b0;
        end else begin
            rom_meta <= rom_data_i;
            rom_sync <= rom_meta;
        end
    end

    // =========================================================
    // Boot chain loader
    // =========================================================
    cucc_boot_state_t state;
    cucc_boot_state_t next_state;
    logic [HALF_CNT_W-1:0] half_cnt;
    logic [HALF_CNT_W-1:0] next_half_cnt;
    logic rom_clk;
    logic next_rom_clk;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic [BOOT_USED-1:0] boot_chain;
    logic [BOOT_USED-1:0] next_boot_chain;
    logic half_tick;

    assign half_tick = (half_cnt == HALF_CNT_W'(ROM_HALF_CYC - 1));

    always_comb begin
        next_state = state;
        next_half_cnt = half_cnt;
        next_rom_clk = rom_clk;
        next_bit_cnt = bit_cnt;
        next_boot_chain = boot_chain;
        case (state)
            CUCC_WAIT_BUILTIN_SELF_TEST: begin
                if (builtin_self_test_done_i) begin
                    next_state = CUCC_SHIFT;
                    next_half_cnt = '0;
                    next_bit_cnt = '0;
                end
            end
            CUCC_SHIFT: begin
                next_half_cnt = half_tick ? '0 : half_cnt + HALF_CNT_W'(1);
                if (half_tick) begin
                    next_rom_clk = ~rom_clk;
                    if (rom_clk) begin
                        next_boot_chain = {boot_chain[BOOT_USED-2:0], rom_sync};
                        next_bit_cnt = bit_cnt + BIT_CNT_W'(1);
                        if (bit_cnt == BIT_CNT_W'(BOOT_BITS - 1)) begin
                            next_state = CUCC_DONE;
                        end
                    end
                end
            end
            CUCC_DONE: begin
                next_rom_clk = 1'b0;
            end
            default: begin
                next_state = CUCC_WAIT_BUILTIN_SELF_TEST;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= CUCC_WAIT_BUILTIN_SELF_TEST;
            half_cnt <= '0;
            rom_clk <= 1'b0;
            bit_cnt <= '0;
            boot_chain <= '0;
        end else begin
            state <= next_state;
            half_cnt <= next_half_cnt;
            rom_clk <= next_rom_clk;
            bit_cnt <= next_bit_cnt;
            boot_chain <= next_boot_chain;
        end
    end

    assign rom_clk_o = rom_clk;
    assign rom_enable_o = (state == CUCC_SHIFT);
    assign cache_ready_o = (state == CUCC_DONE);

    // =========================================================
    // Boot field decode
    // =========================================================
    // field slices
    assign io32_enable_o = boot_chain[POS_IO32];
    assign skewed_fill_bit_o = boot_chain[POS_SKEW];
    assign skewed_fill_dup_o = boot_chain[POS_SKEW_DUP];
    assign victim_threshold_o = boot_chain[POS_VICTIM_LO +: VICTIM_W];
    assign clean_evict_enable_o = boot_chain[POS_CLEAN_EVICT];
    assign system_bus_width_o = boot_chain[POS_BUS_WIDTH_LO +: BUS_WIDTH_W];
    assign system_bus_layout_o = boot_chain[POS_BUS_LAYOUT];
    assign system_clock_multiplier_o = boot_chain[POS_CLK_MULT_LO +: CLK_MULT_W];
    assign shadow_tag_enable_o = boot_chain[POS_SHADOW_TAG];
    assign snoop_tag_only_o = boot_chain[POS_SNOOP_TAG];
    assign fast_mode_enable_o = ~boot_chain[POS_FAST_OFF];

    always_comb begin
        ratio_sel_o = RSEL_1P5;
        ratio_valid_o = 1'b1;
        case (system_clock_multiplier_o)
            MULT_1P5: ratio_sel_o = RSEL_1P5;
            MULT_2P0: ratio_sel_o = RSEL_2P0;
            MULT_2P5: ratio_sel_o = RSEL_2P5;
            MULT_3P0: ratio_sel_o = RSEL_3P0;
            default: ratio_valid_o = 1'b0;
        endcase
    end

    // =========================================================
    // Runtime and error chains
    // =========================================================
    cucc_chain_if #(.W(RT_BITS), .S(STEP_BITS)) rt_if ();
    cucc_chain_if #(.W(ERR_BITS), .S(STEP_BITS)) err_if ();

    cucc_shift_chain #(.W(RT_BITS), .S(STEP_BITS)) u_runtime (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .chain_io(rt_if.chain)
    );

    cucc_shift_chain #(.W(ERR_BITS), .S(STEP_BITS)) u_error (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .chain_io(err_if.chain)
    );

    // =========================================================
    // Privileged register access
    // =========================================================
    logic data_wr;
    logic data_rd;
    logic trig_wr;
    logic [STEP_BITS-1:0] stage;
    logic [STEP_BITS-1:0] next_stage;
    logic pending;
    logic next_pending;
    logic [STEP_BITS-1:0] read_buf;
    logic [STEP_BITS-1:0] next_read_buf;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;

    assign data_wr = preg_priv_i && preg_wr_i && (preg_sel_i == SEL_SERIAL_DATA);
    assign data_rd = preg_priv_i && preg_rd_i && (preg_sel_i == SEL_SERIAL_DATA);
    assign trig_wr = preg_priv_i && preg_wr_i && (preg_sel_i == SEL_SHIFT_TRIGGER)
        && preg_wdata_i[TRIGGER_BIT];

    assign rt_if.load = 1'b0;
    assign rt_if.load_data = '0;
    assign rt_if.shift = pending && preg_retire_i;
    assign rt_if.shift_in = stage;

    assign err_if.load = err_capture_i;
    assign err_if.load_data = err_data_i;
    assign err_if.shift = trig_wr;
    assign err_if.shift_in = '0;

    always_comb begin
        next_stage = stage;
        next_pending = pending;
        next_read_buf = read_buf;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        if (data_wr) begin
            next_stage = preg_wdata_i[STEP_BITS-1:0];
            next_pending = 1'b1;
        end else if (preg_retire_i) begin
            next_pending = 1'b0;
        end
        if (trig_wr) begin
            next_read_buf = err_if.shift_out;
        end
        if (data_rd) begin
            next_rdata = {{(REG_W - STEP_BITS){1'b0}}, read_buf};
            next_rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage <= '0;
            pending <= 1'b0;
            read_buf <= '0;
            rdata <= '0;
            rvalid <= 1'b0;
        end else begin
            stage <= next_stage;
            pending <= next_pending;
            read_buf <= next_read_buf;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign preg_rdata_o = rdata;
    assign preg_rvalid_o = rvalid;
    assign runtime_chain_o = rt_if.value;

    // =========================================================
    // Assertions
    // =========================================================
    property p_boot_count;
        @(posedge clk_i) disable iff (reset_i)
        $rose(cache_ready_o) |-> (bit_cnt == BIT_CNT_W'(BOOT_BITS));
    endproperty
    a_boot_count: assert property (p_boot_count)
        else $error("Boot load ended with wrong bit count");

    property p_ready_hold;
        @(posedge clk_i) disable iff (reset_i)
        cache_ready_o |-> (bit_cnt == BIT_CNT_W'(BOOT_BITS)) && !rom_enable_o;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("Cache ready during boot load");

    property p_boot_shift;
        @(posedge clk_i) disable iff (reset_i)
        (state == CUCC_SHIFT && half_tick && rom_clk) |=>
            (boot_chain[0] == $past(rom_sync)) && (boot_chain[1] == $past(boot_chain[0]));
    endproperty
    a_boot_shift: assert property (p_boot_shift)
        else $error("Boot chain did not shift the ROM bit in");

    property p_stage;
        @(posedge clk_i) disable iff (reset_i)
        data_wr |=> pending && (stage == $past(preg_wdata_i[STEP_BITS-1:0]));
    endproperty
    a_stage: assert property (p_stage)
        else $error("Data write not staged");

    property p_runtime_shift;
        @(posedge clk_i) disable iff (reset_i)
        (pending && preg_retire_i) |=>
            (runtime_chain_o == {$past(runtime_chain_o[RT_BITS-STEP_BITS-1:0]), $past(stage)});
    endproperty
    a_runtime_shift: assert property (p_runtime_shift)
        else $error("Runtime chain did not take six staged bits");

    property p_runtime_still;
        @(posedge clk_i) disable iff (reset_i)
        !(pending && preg_retire_i) |=> $stable(runtime_chain_o);
    endproperty
    a_runtime_still: assert property (p_runtime_still)
        else $error("Runtime chain changed without a retired write");

    property p_err_destroy;
        @(posedge clk_i) disable iff (reset_i)
        (trig_wr && !err_capture_i) |=> (err_if.value[STEP_BITS-1:0] == '0);
    endproperty
    a_err_destroy: assert property (p_err_destroy)
        else $error("Error bits not removed by trigger");

    property p_trigger;
        @(posedge clk_i) disable iff (reset_i)
        trig_wr |=> (read_buf == $past(err_if.value[ERR_BITS-1 -: STEP_BITS]));
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("Trigger did not move error bits");

    property p_read;
        @(posedge clk_i) disable iff (reset_i)
        data_rd |=> preg_rvalid_o && (preg_rdata_o == {{(REG_W - STEP_BITS){1'b0}}, $past(read_buf)});
    endproperty
    a_read: assert property (p_read)
        else $error("Data read returned wrong bits");

    property p_ratio;
        @(posedge clk_i) disable iff (reset_i)
        ratio_valid_o |-> (system_clock_multiplier_o == (CLK_MULT_W'(1) << ratio_sel_o));
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("Clock multiplier decode mismatch");

    property p_fast;
        @(posedge clk_i) disable iff (reset_i)
        cache_ready_o |-> (fast_mode_enable_o != boot_chain[POS_FAST_OFF]);
    endproperty
    a_fast: assert property (p_fast)
        else $error("Fast mode not turned off by its bit");

endmodule : cucc_config_chains

`default_nettype wire

//--- core/cucc_shift_chain.sv
// Purpose: Serial chain that moves a fixed group of bits per step
// Assumes: Parameters match the connected interface
// Notes: Bits leave at the top end, new bits enter at the bottom

`timescale 1ns/10ps
`default_nettype none

module cucc_shift_chain
    import cucc_pkg::*;
#(
    parameter int W = RT_BITS,
    parameter int S = STEP_BITS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Chain access
    cucc_chain_if.chain chain_io
);

    logic [W-1:0] value;
    logic [W-1:0] next_value;

    always_comb begin
        next_value = value;
        if (chain_io.load) begin
            next_value = chain_io.load_data;
        end else if (chain_io.shift) begin
            next_value = {value[W-S-1:0], chain_io.shift_in};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            value <= '0;
        end else begin
            value <= next_value;
        end
    end

    assign chain_io.value = value;
    assign chain_io.shift_out = value[W-1 -: S];

endmodule : cucc_shift_chain

`default_nettype wire

//--- pkg/cucc_chain_if.sv
// Purpose: Connection between the loader and one six-bit stepped chain
// Assumes: Widths match the chain module parameters
// Notes: Load takes priority over shift

`timescale 1ns/10ps
`default_nettype none

interface cucc_chain_if #(
    parameter int W = 36,
    parameter int S = 6
);
    logic load;
    logic [W-1:0] load_data;
    logic shift;
    logic [S-1:0] shift_in;
    logic [S-1:0] shift_out;
    logic [W-1:0] value;

    modport owner (
        output load,
        output load_data,
        output shift,
        output shift_in,
        input shift_out,
        input value
    );

    modport chain (
        input load,
        input load_data,
        input shift,
        input shift_in,
        output shift_out,
        output value
    );
endinterface : cucc_chain_if

`default_nettype wire

//--- pkg/cucc_pkg.sv
// Purpose: Shared constants for the cache unit configuration chains
// Assumes: Core clock of 50 MHz
// Notes: Boot chain field positions count from the least significant end

package cucc_pkg;

    // =========================================================
    // Clock and serial ROM timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 20;
    localparam int ROM_HALF_NS = 100;
    localparam int ROM_HALF_RAW = (ROM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROM_HALF_CYC = (ROM_HALF_RAW < 1) ? 1 : ROM_HALF_RAW;
    localparam int HALF_CNT_W = 8;

    // =========================================================
    // Chain sizes
    // =========================================================
    localparam int BOOT_BITS = 367;
    localparam int BOOT_USED = 303;
    localparam int BIT_CNT_W = 9;
    localparam int RT_BITS = 36;
    localparam int ERR_BITS = 60;
    localparam int STEP_BITS = 6;
    localparam int REG_W = 64;

    // =========================================================
    // Boot chain field positions
    // =========================================================
    localparam int POS_IO32 = 0;
    localparam int POS_SKEW = 1;
    localparam int POS_SKEW_DUP = 2;
    localparam int POS_VICTIM_LO = 3;
    localparam int VICTIM_W = 8;
    localparam int POS_CLEAN_EVICT = 11;
    localparam int POS_BUS_WIDTH_LO = 12;
    localparam int BUS_WIDTH_W = 2;
    localparam int POS_BUS_LAYOUT = 14;
    localparam int POS_CLK_MULT_LO = 15;
    localparam int CLK_MULT_W = 4;
    localparam int POS_SHADOW_TAG = 19;
    localparam int POS_SNOOP_TAG = 20;
    localparam int POS_FAST_OFF = 21;

    // =========================================================
    // Clock multiplier codes
    // =========================================================
    localparam logic [3:0] MULT_1P5 = 4'h1;
    localparam logic [3:0] MULT_2P0 = 4'h2;
    localparam logic [3:0] MULT_2P5 = 4'h4;
    localparam logic [3:0] MULT_3P0 = 4'h8;
    localparam logic [1:0] RSEL_1P5 = 2'h0;
    localparam logic [1:0] RSEL_2P0 = 2'h1;
    localparam logic [1:0] RSEL_2P5 = 2'h2;
    localparam logic [1:0] RSEL_3P0 = 2'h3;

    // =========================================================
    // Privileged register selection
    // =========================================================
    localparam logic SEL_SERIAL_DATA = 1'h0;
    localparam logic SEL_SHIFT_TRIGGER = 1'h1;
    localparam int TRIGGER_BIT = 0;

    typedef enum logic [1:0] {
        CUCC_WAIT_BUILTIN_SELF_TEST,
        CUCC_SHIFT,
        CUCC_DONE
    } cucc_boot_state_t;

endpackage : cucc_pkg

//--- verification/cache_unit_config_chains_tb.sv
// Purpose: Self-checking bench for the cache unit configuration chains
// Assumes: ROM model supplies the boot image
// Notes: One boot per clock multiplier code, then register traffic

`timescale 1ns/10ps
`default_nettype none

module cache_unit_config_chains_tb
    import cucc_pkg::*;
;
    // =========================================================
    // Signals
    // =========================================================
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic builtin_self_test_done_i = 1'b0;
    logic preg_priv_i = 1'b0;
    logic preg_wr_i = 1'b0;
    logic preg_rd_i = 1'b0;
    logic preg_sel_i = 1'b0;
    logic preg_retire_i = 1'b0;
    logic err_capture_i = 1'b0;
    logic [REG_W-1:0] preg_wdata_i = '0;
    logic [ERR_BITS-1:0] err_data_i = '0;
    logic rom_data_i, rom_clk_o, rom_enable_o, preg_rvalid_o, cache_ready_o, io32_enable_o;
    logic skewed_fill_bit_o, skewed_fill_dup_o, clean_evict_enable_o, system_bus_layout_o;
    logic ratio_valid_o, shadow_tag_enable_o, snoop_tag_only_o, fast_mode_enable_o;
    logic [REG_W-1:0] preg_rdata_o;
    logic [VICTIM_W-1:0] victim_threshold_o;
    logic [BUS_WIDTH_W-1:0] system_bus_width_o;
    logic [CLK_MULT_W-1:0] system_clock_multiplier_o;
    logic [1:0] ratio_sel_o;
    logic [RT_BITS-1:0] runtime_chain_o;
    logic [BOOT_BITS-1:0] img = '0;
    logic [RT_BITS-1:0] rt;
    logic [5:0] eq[$];
    logic [5:0] grp;
    logic [63:0] d;
    logic [3:0] codes [5] = '{MULT_1P5, MULT_2P0, MULT_2P5, MULT_3P0, 4'h3};
    int err_count = 0;
    int checked = 0;
    int seed = 32'h9bb1;

    always #10 clk_i = ~clk_i;

    cucc_config_chains dut (
        .clk_i, .reset_i, .builtin_self_test_done_i, .rom_data_i, .rom_clk_o, .rom_enable_o,
        .preg_priv_i, .preg_wr_i, .preg_rd_i, .preg_sel_i, .preg_wdata_i, .preg_retire_i,
        .preg_rdata_o, .preg_rvalid_o, .err_capture_i, .err_data_i, .cache_ready_o,
        .io32_enable_o, .skewed_fill_bit_o, .skewed_fill_dup_o, .victim_threshold_o,
        .clean_evict_enable_o, .system_bus_width_o, .system_bus_layout_o,
        .system_clock_multiplier_o, .ratio_sel_o, .ratio_valid_o, .shadow_tag_enable_o,
        .snoop_tag_only_o, .fast_mode_enable_o, .runtime_chain_o
    );

    cucc_rom_model rom (
        .clk_i, .rom_clk_i(rom_clk_o), .rom_enable_i(rom_enable_o),
        .rom_data_o(rom_data_i), .image_i(img)
    );

    // =========================================================
    // Tasks
    // =========================================================
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, rd, sel, priv, ret, input logic [63:0] wd);
        @(posedge clk_i);
        preg_wr_i <= wr;
        preg_rd_i <= rd;
        preg_sel_i <= sel;
        preg_priv_i <= priv;
        preg_retire_i <= ret;
        preg_wdata_i <= wd;
        @(posedge clk_i);
        preg_wr_i <= 1'b0;
        preg_rd_i <= 1'b0;
        preg_retire_i <= 1'b0;
        #1;
    endtask : acc

    task automatic boot(input logic [3:0] code);
        int n;
        // Top 64 bits are filler that must fall off the chain end
        for (int k = 0; k < BOOT_BITS; k++) begin
            img[k] = 1'($random(seed));
        end
        img[POS_CLK_MULT_LO +: CLK_MULT_W] = code;
        img[POS_SKEW] = (code == MULT_1P5);
        img[POS_SKEW_DUP] = img[POS_SKEW];
        @(posedge clk_i);
        reset_i <= 1'b1;
        builtin_self_test_done_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk(64'({cache_ready_o, rom_enable_o, fast_mode_enable_o}), 64'h1, "reset");
        chk(64'(runtime_chain_o), 64'h0, "runtime reset");
        @(posedge clk_i);
        builtin_self_test_done_i <= 1'b1;
        n = 0;
        while (cache_ready_o !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            n++;
            if (n == 100) begin
                chk(64'({cache_ready_o, rom_enable_o}), 64'h1, "boot busy");
            end
        end
        chk(64'(n >= 2 * ROM_HALF_CYC * BOOT_BITS - 5), 64'h1, "boot early");
        chk(64'(n <= 2 * ROM_HALF_CYC * BOOT_BITS + 10), 64'h1, "boot late");
        #1;
        chk(64'({fast_mode_enable_o, snoop_tag_only_o, shadow_tag_enable_o,
            system_clock_multiplier_o, system_bus_layout_o, system_bus_width_o,
            clean_evict_enable_o, victim_threshold_o, skewed_fill_dup_o,
            skewed_fill_bit_o, io32_enable_o}),
            64'({~img[POS_FAST_OFF], img[POS_SNOOP_TAG:0]}), "boot fields");
    endtask : boot

    task automatic print_verdict;
        $display("Checks made %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        for (int i = 0; i < 5; i++) begin
            boot(codes[i]);
            chk(64'(ratio_valid_o), 64'(i < 4), "ratio valid");
            if (i < 4) begin
                chk(64'(ratio_sel_o), 64'(i), "ratio select");
            end
        end
        $display("Boot test done");
        rt = '0;
        for (int i = 0; i < 8; i++) begin
            d = {$random(seed), $random(seed)};
            acc(1'b1, 1'b0, SEL_SERIAL_DATA, 1'b1, 1'b0, d);
            repeat (($random(seed) & 3)) @(posedge clk_i);
            #1;
            chk(64'(runtime_chain_o), 64'(rt), "staged");
            acc(1'b0, 1'b0, SEL_SERIAL_DATA, 1'b1, 1'b1, 64'h0);
            rt = {rt[RT_BITS-7:0], d[5:0]};
            chk(64'(runtime_chain_o), 64'(rt), "runtime shift");
        end
        acc(1'b1, 1'b0, SEL_SERIAL_DATA, 1'b0, 1'b0, 64'h3F);
        acc(1'b1, 1'b0, SEL_SHIFT_TRIGGER, 1'b1, 1'b1, 64'h1);
        acc(1'b0, 1'b0, SEL_SERIAL_DATA, 1'b1, 1'b1, 64'h0);
        chk(64'(runtime_chain_o), 64'(rt), "runtime guarded");
        $display("Runtime chain test done");
        @(posedge clk_i);
        err_data_i <= 60'({$random(seed), $random(seed)});
        err_capture_i <= 1'b1;
        @(posedge clk_i);
        err_capture_i <= 1'b0;
        for (int g = 9; g >= 0; g--) begin
            eq.push_back(err_data_i[g*6 +: 6]);
        end
        for (int i = 0; i < 11; i++) begin
            if (i == 3) begin
                acc(1'b1, 1'b0, SEL_SHIFT_TRIGGER, 1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFE);
                acc(1'b1, 1'b0, SEL_SHIFT_TRIGGER, 1'b0, 1'b0, 64'h1);
                acc(1'b0, 1'b1, SEL_SERIAL_DATA, 1'b1, 1'b0, 64'h0);
                chk(preg_rdata_o, 64'(grp), "refused trigger");
            end
            d = {$random(seed), $random(seed)};
            acc(1'b1, 1'b0, SEL_SHIFT_TRIGGER, 1'b1, 1'b0, d | 64'h1);
            grp = (eq.size() > 0) ? eq.pop_front() : 6'h0;
            acc(1'b0, 1'b1, SEL_SERIAL_DATA, 1'b1, 1'b0, 64'h0);
            chk(64'(preg_rvalid_o), 64'h1, "read answer");
            chk(preg_rdata_o, 64'(grp), "error read");
        end
        $display("Error chain test done");
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
endmodule : cache_unit_config_chains_tb

`default_nettype wire

//--- verification/cucc_rom_model.sv
// Purpose: Serial configuration ROM seen from the boot loader
// Assumes: Image bit k is meant for boot chain position k
// Notes: Released data line shows a value that changes every cycle

`timescale 1ns/10ps
`default_nettype none

module cucc_rom_model
    import cucc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // ROM pins
    input wire logic rom_clk_i,
    input wire logic rom_enable_i,
    output logic rom_data_o,
    // Stored image
    input wire logic [BOOT_BITS-1:0] image_i
);
    // =========================================================
    // Bit pointer
    // =========================================================
    int idx = BOOT_BITS - 1;
    logic clk_q = 1'b0;
    logic last = 1'b0;

    always @(posedge clk_i) begin
        clk_q <= rom_clk_i;
        if (!rom_enable_i) begin
            idx <= BOOT_BITS - 1;
        end else if (clk_q && !rom_clk_i && idx > 0) begin
            idx <= idx - 1;
        end
        last <= rom_data_o;
    end

    // No pull on the line, so idle data keeps toggling
    assign rom_data_o = rom_enable_i ? image_i[idx] : ~last;
endmodule : cucc_rom_model

`default_nettype wire
